// ===== eers_pkg.sv
`default_nettype none
package eers_pkg;
	// Array geometry and byte framing
	localparam int ADDR_W = 10;
	localparam int MEM_WORDS = 1024;
	localparam int BYTE_W = 8;
	localparam int BYTE_MSB = 7;
	localparam int PAGE_W = 4;
	localparam logic [9:0] ADDR_ONE = 10'h001;
	localparam logic [3:0] PAGE_ONE = 4'h1;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	// Device address word: type nibble, select bit, page bits, read/write
	localparam logic [3:0] DEV_TYPE = 4'ha;
	localparam int DA_TYPE_LSB = 4;
	localparam int DA_SEL = 3;
	localparam int DA_PAGE_LSB = 1;
	localparam int DA_RW = 0;
	localparam logic DA_READ = 1'h1;
	localparam logic DA_WRITE = 1'h0;
	// Internal program time and its cycle count at the 4 ns clock
	localparam int CLK_NS = 4;
	localparam int PROG_TIME_MS = 3;
	localparam int PROG_CYC = PROG_TIME_MS * 1000000 / CLK_NS;
	localparam int PROG_CNT_W = 20;
	localparam logic [19:0] PROG_ONE = 20'h0_0001;
	// Controller bit timing: four quarters per bus bit
	localparam logic [2:0] QTR_LAST = 3'h3;
	localparam logic [2:0] DIV_ONE = 3'h1;
	localparam logic [1:0] QP_SET = 2'h0;
	localparam logic [1:0] QP_RISE = 2'h1;
	localparam logic [1:0] QP_SAMP = 2'h2;
	localparam logic [1:0] QP_END = 2'h3;
	localparam logic [1:0] Q_ONE = 2'h1;
	localparam logic [7:0] LEN_ONE = 8'h01;
	typedef enum logic [4:0] {
		DS_IDLE = 5'h01,
		DS_RX = 5'h02,
		DS_RXACK = 5'h04,
		DS_TX = 5'h08,
		DS_TXACK = 5'h10
	} eers_dst_t;
	typedef enum logic [4:0] {
		CS_IDLE = 5'h01,
		CS_START = 5'h02,
		CS_SEND = 5'h04,
		CS_RECV = 5'h08,
		CS_STOP = 5'h10
	} eers_cst_t;
	typedef enum logic [1:0] {
		K_DEV = 2'h0,
		K_WADR = 2'h1,
		K_DATA = 2'h2
	} eers_kind_t;
	typedef enum logic [1:0] {
		ST_DEVW = 2'h0,
		ST_WADR = 2'h1,
		ST_WDAT = 2'h2,
		ST_DEVR = 2'h3
	} eers_stage_t;
endpackage
`default_nettype wire

// ===== eers_if.sv
`timescale 1ns/10ps
`default_nettype none
interface eers_if;
	logic scl;
	logic sda_ctl_o;
	logic sda_ctl_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic sda;
	// Open-drain wire with pull-up: low whenever an enabled driver pulls low
	assign sda = ~((sda_ctl_oe & ~sda_ctl_o) | (sda_dev_oe & ~sda_dev_o));
	modport dev(input scl, input sda, output sda_dev_o, output sda_dev_oe);
	modport ctl(output scl, input sda, output sda_ctl_o, output sda_ctl_oe);
endinterface
`default_nettype wire

// ===== eers_dev.sv
`timescale 1ns/10ps
`default_nettype none
module eers_dev #(
	parameter int unsigned P_PROG_CYC = eers_pkg::PROG_CYC
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_hardwired_select_pin,
	eers_if.dev bus,
	output logic o_prog_busy
);
	typedef struct packed {
		eers_pkg::eers_dst_t state;
		logic scl_s1;
		logic scl_s2;
		logic scl_p;
		logic sda_s1;
		logic sda_s2;
		logic sda_p;
		logic sel_s1;
		logic sel_s2;
		logic [3:0] cnt;
		eers_pkg::eers_kind_t kind;
		logic [7:0] shreg;
		logic [9:0] addr;
		logic [1:0] page;
		logic rw;
		logic acked;
		logic wrote;
		logic [19:0] prog_cnt;
		logic prog_busy;
		logic sda_oe;
	} eers_dev_st_t;

	eers_dev_st_t r;
	eers_dev_st_t n;
	logic [7:0] mem [0:eers_pkg::MEM_WORDS-1];
	logic [7:0] mem_rd;
	logic mem_we;
	logic load;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;

	// Bus events seen on the synchronised pins
	assign scl_rise = r.scl_s2 & ~r.scl_p;
	assign scl_fall = ~r.scl_s2 & r.scl_p;
	assign start_c = r.scl_s2 & r.scl_p & r.sda_p & ~r.sda_s2;
	assign stop_c = r.scl_s2 & r.scl_p & ~r.sda_p & r.sda_s2;
	assign mem_rd = mem[r.addr];

	// Open-drain: only ever pull low
	assign bus.sda_dev_o = 1'h0;
	assign bus.sda_dev_oe = r.sda_oe;
	assign o_prog_busy = r.prog_busy;

	// Next-state logic
	always_comb begin
		n = r;
		load = 1'h0;
		mem_we = 1'h0;
		n.scl_s1 = bus.scl;
		n.scl_s2 = r.scl_s1;
		n.scl_p = r.scl_s2;
		n.sda_s1 = bus.sda;
		n.sda_s2 = r.sda_s1;
		n.sda_p = r.sda_s2;
		n.sel_s1 = i_hardwired_select_pin;
		n.sel_s2 = r.sel_s1;
		// Program timer counts down to zero
		if (r.prog_cnt != '0) begin
			n.prog_cnt = r.prog_cnt - eers_pkg::PROG_ONE;
		end
		if (start_c && !r.prog_busy) begin
			// Start or repeated start: expect a device address word
			n.state = eers_pkg::DS_RX;
			n.kind = eers_pkg::K_DEV;
			n.cnt = '0;
			n.sda_oe = 1'h0;
		end else if (stop_c) begin
			// Stop ends any sequence and lets go of the wire
			n.state = eers_pkg::DS_IDLE;
			n.sda_oe = 1'h0;
			n.wrote = 1'h0;
			if (r.wrote) begin
				n.prog_cnt = P_PROG_CYC[eers_pkg::PROG_CNT_W-1:0];
			end
		end else begin
			case (r.state)
				eers_pkg::DS_RX: begin
					if (scl_rise) begin
						// Shift in, most significant bit first
						n.shreg = {r.shreg[eers_pkg::BYTE_MSB-1:0], r.sda_s2};
						n.cnt = r.cnt + eers_pkg::CNT_ONE;
					end
					if (scl_fall && r.cnt == eers_pkg::ACK_SLOT) begin
						n.state = eers_pkg::DS_RXACK;
						n.sda_oe = 1'h1;
						case (r.kind)
							eers_pkg::K_DEV: begin
								n.rw = r.shreg[eers_pkg::DA_RW];
								n.page = r.shreg[eers_pkg::DA_PAGE_LSB +: 2];
								if (r.shreg[eers_pkg::DA_TYPE_LSB +: 4] != eers_pkg::DEV_TYPE ||
										r.shreg[eers_pkg::DA_SEL] != r.sel_s2) begin
									// No match: stay silent until next start
									n.state = eers_pkg::DS_IDLE;
									n.sda_oe = 1'h0;
								end
							end
							eers_pkg::K_WADR: begin
								// Dummy write loads the word address
								n.addr = {r.page, r.shreg};
							end
							default: begin
								// Written byte, address rolls within the page
								mem_we = 1'h1;
								n.wrote = 1'h1;
								n.addr = {r.addr[eers_pkg::ADDR_W-1:eers_pkg::PAGE_W],
									r.addr[eers_pkg::PAGE_W-1:0] + eers_pkg::PAGE_ONE};
							end
						endcase
					end
				end
				eers_pkg::DS_RXACK: begin
					if (scl_fall) begin
						n.sda_oe = 1'h0;
						n.cnt = '0;
						n.state = eers_pkg::DS_RX;
						if (r.kind == eers_pkg::K_DEV && r.rw == eers_pkg::DA_READ) begin
							load = 1'h1;
						end else if (r.kind == eers_pkg::K_DEV) begin
							n.kind = eers_pkg::K_WADR;
						end else begin
							n.kind = eers_pkg::K_DATA;
						end
					end
				end
				eers_pkg::DS_TX: begin
					if (scl_fall) begin
						if (r.cnt == eers_pkg::LAST_BIT) begin
							// Free the wire for the ninth clock
							n.sda_oe = 1'h0;
							n.state = eers_pkg::DS_TXACK;
						end else begin
							// Next bit goes out just after SCL falls
							n.shreg = {r.shreg[eers_pkg::BYTE_MSB-1:0], 1'h0};
							n.cnt = r.cnt + eers_pkg::CNT_ONE;
							n.sda_oe = ~r.shreg[eers_pkg::BYTE_MSB-1];
						end
					end
				end
				eers_pkg::DS_TXACK: begin
					if (scl_rise) begin
						n.acked = ~r.sda_s2;
					end
					if (scl_fall) begin
						if (r.acked) begin
							load = 1'h1;
						end else begin
							n.state = eers_pkg::DS_IDLE;
						end
					end
				end
				eers_pkg::DS_IDLE: begin
					n.sda_oe = 1'h0;
				end
				default: begin
					n.state = eers_pkg::DS_IDLE;
					n.sda_oe = 1'h0;
				end
			endcase
		end
		// Fetch byte at counter, drive its MSB, count past it
		if (load) begin
			n.shreg = mem_rd;
			n.cnt = '0;
			n.state = eers_pkg::DS_TX;
			n.sda_oe = ~mem_rd[eers_pkg::BYTE_MSB];
			n.addr = r.addr + eers_pkg::ADDR_ONE;
		end
		n.prog_busy = (n.prog_cnt != '0);
	end

	// State register; the address counter survives between transactions
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			r <= '0;
			r.state <= eers_pkg::DS_IDLE;
		end else begin
			r <= n;
		end
	end

	// Array write port
	always_ff @(posedge i_clk) begin
		if (mem_we) begin
			mem[r.addr] <= r.shreg;
		end
	end
endmodule
`default_nettype wire

// ===== eers_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module eers_ctl (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_go,
	input wire logic i_rand,
	input wire logic i_write,
	input wire logic i_sel,
	input wire logic [9:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] i_len,
	eers_if.ctl bus,
	output logic o_busy,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	output logic o_nack,
	output logic o_done
);
	typedef struct packed {
		eers_pkg::eers_cst_t state;
		eers_pkg::eers_stage_t stage;
		logic [2:0] div;
		logic [1:0] q;
		logic [3:0] bitn;
		logic [7:0] shreg;
		logic acked;
		logic [7:0] left;
		logic scl;
		logic sda_oe;
		logic sda_s1;
		logic sda_s2;
		logic write;
		logic sel;
		logic [9:0] addr;
		logic [7:0] wdata;
		logic busy;
		logic [7:0] rdata;
		logic rvalid;
		logic nack;
		logic done;
	} eers_ctl_st_t;

	eers_ctl_st_t r;
	eers_ctl_st_t n;
	logic tick;
	logic bit_a;
	logic bit_b;
	logic data_bit;

	assign tick = (r.div == eers_pkg::QTR_LAST);
	assign data_bit = (r.bitn != eers_pkg::ACK_SLOT);
	assign bus.scl = r.scl;
	assign bus.sda_ctl_o = 1'h0;
	assign bus.sda_ctl_oe = r.sda_oe;
	assign o_busy = r.busy;
	assign o_rdata = r.rdata;
	assign o_rvalid = r.rvalid;
	assign o_nack = r.nack;
	assign o_done = r.done;

	// SDA level for the low half (a) and late high half (b) of a symbol
	always_comb begin
		bit_a = 1'h1;
		bit_b = 1'h1;
		case (r.state)
			eers_pkg::CS_START: begin
				bit_b = 1'h0;
			end
			eers_pkg::CS_STOP: begin
				bit_a = 1'h0;
			end
			eers_pkg::CS_SEND: begin
				bit_a = data_bit ? r.shreg[eers_pkg::BYTE_MSB] : 1'h1;
				bit_b = bit_a;
			end
			eers_pkg::CS_RECV: begin
				// Ack while more bytes wanted, else leave high
				bit_a = data_bit ? 1'h1 : (r.left == eers_pkg::LEN_ONE);
				bit_b = bit_a;
			end
			default: begin
				bit_a = 1'h1;
				bit_b = 1'h1;
			end
		endcase
	end

	// Symbol sequencer
	always_comb begin
		n = r;
		n.rvalid = 1'h0;
		n.done = 1'h0;
		n.sda_s1 = bus.sda;
		n.sda_s2 = r.sda_s1;
		if (r.state == eers_pkg::CS_IDLE) begin
			n.div = '0;
			n.q = eers_pkg::QP_SET;
			if (i_go) begin
				n.state = eers_pkg::CS_START;
				n.stage = (i_rand | i_write) ? eers_pkg::ST_DEVW : eers_pkg::ST_DEVR;
				n.write = i_write;
				n.sel = i_sel;
				n.addr = i_addr;
				n.wdata = i_wdata;
				n.left = (i_len == '0) ? eers_pkg::LEN_ONE : i_len;
				n.busy = 1'h1;
				n.nack = 1'h0;
			end
		end else begin
			n.div = tick ? '0 : r.div + eers_pkg::DIV_ONE;
			if (tick) begin
				n.q = r.q + eers_pkg::Q_ONE;
				case (r.q)
					eers_pkg::QP_SET: begin
						n.sda_oe = ~bit_a;
					end
					eers_pkg::QP_RISE: begin
						n.scl = 1'h1;
					end
					eers_pkg::QP_SAMP: begin
						n.sda_oe = ~bit_b;
						if (r.state == eers_pkg::CS_SEND) begin
							n.acked = ~r.sda_s2;
						end
						if (r.state == eers_pkg::CS_RECV && data_bit) begin
							n.shreg = {r.shreg[eers_pkg::BYTE_MSB-1:0], r.sda_s2};
						end
					end
					default: begin
						n.scl = (r.state == eers_pkg::CS_STOP);
						n.bitn = r.bitn + eers_pkg::CNT_ONE;
						case (r.state)
							eers_pkg::CS_START: begin
								// Address word: type, select, page, direction
								n.state = eers_pkg::CS_SEND;
								n.bitn = '0;
								n.shreg = {eers_pkg::DEV_TYPE, r.sel,
									r.addr[eers_pkg::ADDR_W-1:eers_pkg::BYTE_W],
									(r.stage == eers_pkg::ST_DEVR) ? eers_pkg::DA_READ
									: eers_pkg::DA_WRITE};
							end
							eers_pkg::CS_SEND: begin
								if (data_bit) begin
									n.shreg = {r.shreg[eers_pkg::BYTE_MSB-1:0], 1'h0};
								end else if (!r.acked) begin
									n.nack = 1'h1;
									n.state = eers_pkg::CS_STOP;
								end else begin
									n.bitn = '0;
									case (r.stage)
										eers_pkg::ST_DEVW: begin
											n.stage = eers_pkg::ST_WADR;
											n.shreg = r.addr[eers_pkg::BYTE_W-1:0];
										end
										eers_pkg::ST_WADR: begin
											if (r.write) begin
												n.stage = eers_pkg::ST_WDAT;
												n.shreg = r.wdata;
											end else begin
												n.stage = eers_pkg::ST_DEVR;
												n.state = eers_pkg::CS_START;
											end
										end
										eers_pkg::ST_WDAT: begin
											n.state = eers_pkg::CS_STOP;
										end
										default: begin
											n.state = eers_pkg::CS_RECV;
										end
									endcase
								end
							end
							eers_pkg::CS_RECV: begin
								if (!data_bit) begin
									n.rdata = r.shreg;
									n.rvalid = 1'h1;
									n.bitn = '0;
									n.left = r.left - eers_pkg::LEN_ONE;
									if (r.left == eers_pkg::LEN_ONE) begin
										n.state = eers_pkg::CS_STOP;
									end
								end
							end
							default: begin
								n.state = eers_pkg::CS_IDLE;
								n.busy = 1'h0;
								n.done = 1'h1;
							end
						endcase
					end
				endcase
			end
		end
	end

	// State register; bus idles with SCL high and SDA released
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			r <= '0;
			r.state <= eers_pkg::CS_IDLE;
			r.stage <= eers_pkg::ST_DEVW;
			r.scl <= 1'h1;
			r.sda_s1 <= 1'h1;
			r.sda_s2 <= 1'h1;
		end else begin
			r <= n;
		end
	end
endmodule
`default_nettype wire

// ===== eers_properties.sv
`timescale 1ns/10ps
`default_nettype none
module eers_properties #(
	parameter int unsigned P_PROG_CYC = 200
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_dev_oe,
	input wire logic sda_ctl_oe,
	input wire logic o_prog_busy
);
	logic [19:0] busy_cnt_q;
	logic [19:0] busy_cnt_d;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// Length of the current program-busy stretch
	always_comb begin
		busy_cnt_d = o_prog_busy ? busy_cnt_q + 20'h0_0001 : 20'h0_0000;
	end
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			busy_cnt_q <= 20'h0_0000;
		end else begin
			busy_cnt_q <= busy_cnt_d;
		end
	end
	dev_edge_a: assert property ($changed(sda_dev_oe) |-> !scl && !$past(scl, 3))
		else $error("device data moved outside clock low");
	no_fight_a: assert property (scl |-> !(sda_dev_oe && sda_ctl_oe))
		else $error("both ends pull data while clock high");
	bit_hold_a: assert property ($rose(sda_dev_oe) |=> sda_dev_oe [*8])
		else $error("device low bit too short");
	stop_release_a: assert property (scl && $rose(sda) |=> !sda_dev_oe [*8])
		else $error("device drives after stop");
	start_release_a: assert property (scl && $past(scl) && $fell(sda) |=> !sda_dev_oe [*6])
		else $error("device drives after start");
	prog_quiet_a: assert property (o_prog_busy |-> !sda_dev_oe)
		else $error("device answers while programming");
	prog_bound_a: assert property (busy_cnt_q <= 20'(P_PROG_CYC + 8))
		else $error("program time too long");
	prog_start_a: assert property ($rose(o_prog_busy) |-> scl && sda)
		else $error("program began without stop");
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam int P_CYC = 200;
	logic i_clk;
	logic i_srst;
	logic i_go;
	logic i_rand;
	logic i_write;
	logic i_sel;
	logic [9:0] i_addr;
	logic [7:0] i_wdata;
	logic [7:0] i_len;
	logic o_busy;
	logic [7:0] o_rdata;
	logic o_rvalid;
	logic o_nack;
	logic o_done;
	logic o_prog_busy;
	logic [8:0] exp_q[$];
	logic [7:0] mem_m[1024];
	logic [9:0] wa[6] = '{10'h3fe, 10'h3ff, 10'h000, 10'h001, 10'h155, 10'h156};
	logic [9:0] cur_a = 10'h000;
	logic [8:0] wire_sh = 9'h000;
	logic [8:0] exp_v;
	logic [31:0] seed = 32'h4a91;
	logic nk;
	logic sel_pin;
	int num_errors = 0;
	int comparisons = 0;
	eers_if bus();
	eers_dev #(.P_PROG_CYC(P_CYC)) i_eers_dev (.i_clk(i_clk), .i_srst(i_srst),
		.i_hardwired_select_pin(sel_pin), .bus(bus), .o_prog_busy(o_prog_busy));
	eers_ctl i_eers_ctl (.i_clk(i_clk), .i_srst(i_srst), .i_go(i_go), .i_rand(i_rand),
		.i_write(i_write), .i_sel(i_sel), .i_addr(i_addr), .i_wdata(i_wdata), .i_len(i_len),
		.bus(bus), .o_busy(o_busy), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_nack(o_nack),
		.o_done(o_done));
	eers_properties #(.P_PROG_CYC(P_CYC)) i_eers_properties (.i_clk(i_clk), .i_srst(i_srst),
		.scl(bus.scl), .sda(bus.sda), .sda_dev_oe(bus.sda_dev_oe), .sda_ctl_oe(bus.sda_ctl_oe),
		.o_prog_busy(o_prog_busy));
	// Clock source
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// One controller transfer; notes expected bytes, returns the address-ack outcome
	task automatic op(input logic wr, rnd, sel, ok, input logic [9:0] adr,
		input logic [7:0] len, output logic nak);
		int i;
		int n;
		logic [9:0] a;
		n = (len == 8'h00) ? 1 : len;
		a = rnd ? adr : cur_a;
		seed = lfsr(seed);
		if (wr) begin
			mem_m[adr] = seed[7:0];
		end else if (ok) begin
			for (i = 0; i < n; i++) begin
				exp_q.push_back({i == n - 1, mem_m[a]});
				a++;
			end
			cur_a = a;
		end
		@(posedge i_clk);
		i_go <= 1'b1;
		i_write <= wr;
		i_rand <= rnd;
		i_sel <= sel;
		i_addr <= adr;
		i_len <= len;
		i_wdata <= seed[7:0];
		@(posedge i_clk);
		i_go <= 1'b0;
		@(negedge i_clk);
		check({8'h00, o_busy}, 9'h001);
		for (i = 0; i < 9000 && o_done !== 1'b1; i++) begin
			@(negedge i_clk);
		end
		// A transfer that never finishes counts against the run
		check({8'h00, o_done}, 9'h001);
		check({8'h00, o_busy}, 9'h000);
		nak = o_nack;
	endtask
	// Data bits as seen on the wire at each clock rise
	always @(posedge bus.scl) begin
		wire_sh <= {wire_sh[7:0], bus.sda};
	end
	// Result watcher: oldest note against each delivered byte, mid-cycle
	always @(negedge i_clk) begin
		if (o_rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check({1'b1, o_rdata}, 9'h000);
			end else begin
				exp_v = exp_q.pop_front();
				check({1'b0, o_rdata}, {1'b0, exp_v[7:0]});
				check(wire_sh, {exp_v[7:0], exp_v[8]});
			end
		end
	end
	initial begin
		repeat (60000) @(posedge i_clk);
		num_errors++;
		wrap_up();
	end
	// Main sequence
	initial begin
		i_srst = 1'b1;
		sel_pin = 1'b1;
		i_go = 1'b0;
		i_rand = 1'b0;
		i_write = 1'b0;
		i_sel = 1'b1;
		i_addr = 10'h000;
		i_wdata = 8'h00;
		i_len = 8'h00;
		repeat (5) @(posedge i_clk);
		i_srst <= 1'b0;
		foreach (wa[k]) begin
			op(1'b1, 1'b0, 1'b1, 1'b1, wa[k], 8'h01, nk);
			check({8'h00, nk}, 9'h000);
			if (k == 0) begin
				op(1'b0, 1'b0, 1'b1, 1'b0, 10'h000, 8'h01, nk);
				check({8'h00, nk}, 9'h001);
			end
			for (int i = 0; i < P_CYC + 20 && o_prog_busy !== 1'b0; i++) begin
				@(negedge i_clk);
			end
			check({8'h00, o_prog_busy}, 9'h000);
		end
		op(1'b0, 1'b1, 1'b1, 1'b1, 10'h3fe, 8'h03, nk);
		check({8'h00, nk}, 9'h000);
		op(1'b0, 1'b0, 1'b1, 1'b1, 10'h000, 8'h00, nk);
		check({8'h00, nk}, 9'h000);
		op(1'b0, 1'b1, 1'b1, 1'b1, 10'h155, 8'h01, nk);
		check({8'h00, nk}, 9'h000);
		op(1'b0, 1'b0, 1'b0, 1'b0, 10'h000, 8'h01, nk);
		check({8'h00, nk}, 9'h001);
		op(1'b0, 1'b0, 1'b1, 1'b1, 10'h000, 8'h01, nk);
		check({8'h00, nk}, 9'h000);
		// Strap the select pin low: only a low select bit is answered now
		@(posedge i_clk);
		sel_pin <= 1'b0;
		op(1'b0, 1'b1, 1'b0, 1'b1, 10'h3ff, 8'h01, nk);
		check({8'h00, nk}, 9'h000);
		op(1'b0, 1'b0, 1'b0, 1'b1, 10'h000, 8'h02, nk);
		check({8'h00, nk}, 9'h000);
		repeat (4) @(posedge i_clk);
		check(9'(exp_q.size()), 9'h000);
		wrap_up();
	end
endmodule
`default_nettype wire
